// ### core/uim_token_phy_regs.sv
// Purpose: usb interface manager frame, token and phy control registers
// Assumes: apb slave, zero wait states, tokens already crc/pid checked
// Notes: one clock, synchronous active high reset
// Notes on behaviour
// - 11-bit frame counter, software read/write
// - last received packet identifier, read only
// - endpoint valid flag, zero after reset
// - copy of last token endpoint number
// - special endpoints delivered ORed with 0x10
// - 32-bit session flag mask, reset zero
// - power signalling data plus valid bit
// - control bit switches off port pulldowns
// - se0 auto-resume sets sticky reset flag
// - k auto-resume sets sticky resume flag
// - linestate change delayed two-to-field cycles
// - suspend controller resumes when bit set
// - config field drives transceiver config pins
// - only tokens matching device address pass
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module uim_token_phy_regs #(
    parameter int DLY_CNT_W = 16 // width of the linestate delay counter
) (
    input wire logic clk_sys_in, // system clock, 250 MHz
    input wire logic reset_in, // synchronous reset, active high
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [uim_pkg::ADDR_W-1:0] paddr_in, // apb address
    input wire logic [uim_pkg::DATA_W-1:0] pwdata_in, // apb write data
    output logic [uim_pkg::DATA_W-1:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error on unmapped address
    input wire logic tok_valid_in, // decoded token strobe
    input wire logic [3:0] tok_pid_in, // token packet identifier
    input wire logic [6:0] tok_addr_in, // token device address
    input wire logic [3:0] tok_endp_in, // token endpoint number
    input wire logic sof_valid_in, // start of frame strobe
    input wire logic [10:0] sof_frame_in, // frame number of sof
    output logic rx_valid_out, // receive port endpoint strobe
    output logic [4:0] rx_endp_out, // receive port endpoint
    input wire logic [1:0] linestate_in, // raw phy linestate
    output logic [1:0] linestate_filt_out, // filtered linestate
    input wire logic suspended_in, // link is in suspend
    output logic resume_out, // auto-resume pulse
    output logic first_byte_port_pd_off_out, // pulldowns off, port one
    output logic second_byte_port_pd_off_out, // pulldowns off, port two
    output logic [2:0] transceiver_config_pins_out, // phy config pins
    output logic [31:0] session_flag_mask_out, // session flag mask
    output logic [7:0] power_sig_data_out, // power signalling data
    output logic power_sig_valid_out, // power signalling valid
    output logic irq_out // level interrupt
);
    import uim_pkg::*;

    // block overview, in short:
    // - apb slave with zero wait states
    // - read data is captured in the setup cycle
    // - writes land on the access edge only
    // - token side filters on the device address
    // - accepted tokens update pid and endpoint
    // - receive port tags special endpoints
    // - linestate filter feeds the resume logic
    // - cause flags are sticky until written zero
    // - one level interrupt from status and mask

    logic [DEV_ADDR_W-1:0] dev_addr_ff; // programmed device address
    logic [FRAME_W-1:0] frame_cnt_ff; // frame counter
    logic [3:0] pid_ff; // last packet identifier
    logic [3:0] endp_ff; // last endpoint number
    logic endp_valid_ff; // endpoint holds a value
    logic [15:0] special_ff; // special endpoint mask
    logic [31:0] sess_mask_ff; // session flag mask
    logic [8:0] power_ff; // power valid and data
    logic [31:0] xcvr_ctl_ff; // transceiver control
    logic [IRQ_W-1:0] irq_stat_ff; // sticky event bits
    logic [IRQ_W-1:0] irq_mask_ff; // interrupt enables
    logic [DATA_W-1:0] prdata_ff; // read data, loaded at setup
    logic rx_valid_ff; // receive strobe
    logic [4:0] rx_endp_ff; // receive endpoint
    logic [1:0] ls_filt_ff; // filtered linestate
    logic [1:0] ls_cand_ff; // candidate linestate
    logic [DLY_CNT_W-1:0] ls_cnt_ff; // stability count
    logic resume_ff; // resume pulse
    logic wr_en; // apb write takes effect
    logic rd_setup; // apb read setup cycle
    logic tok_ok; // token accepted
    logic res_k; // auto-resume by k
    logic res_se0; // auto-resume by se0
    logic [IRQ_W-1:0] events; // event set vector
    logic [DLY_CNT_W-1:0] ls_limit; // filter length minus one

    // decode of an address onto a mapped register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            DEV_ADDR_OFS, FRAME_CNT_OFS, PID_OFS, ENDP_OFS: is_mapped = 1'b1;
            SPECIAL_OFS, SESS_MASK_OFS, POWER_OFS: is_mapped = 1'b1;
            XCVR_CTL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // write hit on one register
    function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
        wr_hit = wr_en && (paddr_in == ofs);
    endfunction

    // zero wait states; writes land at the access edge
    assign wr_en = psel_in && penable_in && pwrite_in && is_mapped(paddr_in);
    assign rd_setup = psel_in && !penable_in && !pwrite_in;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !is_mapped(paddr_in);
    assign prdata_out = prdata_ff;

    // token passes only on device address match
    assign tok_ok = tok_valid_in && (tok_addr_in == dev_addr_ff);

    // suspend controller resumes only while enabled
    assign res_k = xcvr_ctl_ff[SUSP_CTL_BIT] && suspended_in
        && (ls_filt_ff == LS_K);
    assign res_se0 = xcvr_ctl_ff[SUSP_CTL_BIT] && suspended_in
        && (ls_filt_ff == LS_SE0);

    // event vector for the interrupt status
    always_comb begin
        events = '0;
        events[IRQ_TOKEN] = tok_ok;
        events[IRQ_SOF] = sof_valid_in;
        events[IRQ_RES_K] = res_k;
        events[IRQ_RES_SE0] = res_se0;
    end

    // read path notes:
    // data is latched when psel rises with
    // penable low, so the access phase sees a
    // settled word and pready can stay high.
    // an unmapped address reads as zero.
    // reserved bits are never loaded, so they
    // stay zero from the clear at the top.
    // writes never touch this register.
    // read mux, sampled in the setup cycle
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prdata_ff <= REG_RST;
        end else if (rd_setup) begin
            prdata_ff <= REG_RST;
            case (paddr_in)
                DEV_ADDR_OFS: prdata_ff[DEV_ADDR_W-1:0] <= dev_addr_ff;
                FRAME_CNT_OFS: prdata_ff[FRAME_W-1:0] <= frame_cnt_ff;
                PID_OFS: prdata_ff[3:0] <= pid_ff;
                ENDP_OFS: prdata_ff[4:0] <= {endp_valid_ff, endp_ff};
                SPECIAL_OFS: prdata_ff[15:0] <= special_ff;
                SESS_MASK_OFS: prdata_ff <= sess_mask_ff;
                POWER_OFS: prdata_ff[8:0] <= power_ff;
                XCVR_CTL_OFS: prdata_ff <= xcvr_ctl_ff;
                IRQ_STAT_OFS: prdata_ff[IRQ_W-1:0] <= irq_stat_ff;
                IRQ_MASK_OFS: prdata_ff[IRQ_W-1:0] <= irq_mask_ff;
                default: prdata_ff <= REG_RST;
            endcase
        end
    end

    // device address, zero until enumerated
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            dev_addr_ff <= '0;
        end else if (wr_hit(DEV_ADDR_OFS)) begin
            dev_addr_ff <= pwdata_in[DEV_ADDR_W-1:0];
        end
    end

    // frame counter notes:
    // the line is the authority on the frame,
    // so a start of frame beats software.
    // software may preset it before the first
    // frame, for tests or a resync.
    // both fields share one 11-bit counter.
    // frame counter: sof token wins over a software write
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            frame_cnt_ff <= '0;
        end else if (sof_valid_in) begin
            frame_cnt_ff <= sof_frame_in;
        end else if (wr_hit(FRAME_CNT_OFS)) begin
            frame_cnt_ff <= pwdata_in[FRAME_W-1:0];
        end
    end

    // last pid and endpoint from each accepted token
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pid_ff <= '0;
            endp_ff <= '0;
            endp_valid_ff <= 1'b0;
        end else if (tok_ok) begin
            pid_ff <= tok_pid_in;
            endp_ff <= tok_endp_in;
            endp_valid_ff <= 1'b1;
        end
    end

    // receive port notes:
    // the strobe is high one cycle per token and
    // follows the accepted token by one edge.
    // the endpoint holds between strobes, so
    // a slow reader sees the last one.
    // tokens for other addresses give no sign.
    // receive port endpoint with special tag
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rx_valid_ff <= 1'b0;
            rx_endp_ff <= '0;
        end else begin
            rx_valid_ff <= tok_ok;
            if (tok_ok) begin
                rx_endp_ff <= {1'b0, tok_endp_in}
                    | (special_ff[tok_endp_in] ? SPECIAL_TAG : 5'h00);
            end
        end
    end

    // plain software registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            special_ff <= '0;
            sess_mask_ff <= REG_RST;
            power_ff <= '0;
            irq_mask_ff <= '0;
        end else begin
            if (wr_hit(SPECIAL_OFS)) begin
                special_ff <= pwdata_in[15:0];
            end
            if (wr_hit(SESS_MASK_OFS)) begin
                sess_mask_ff <= pwdata_in;
            end
            if (wr_hit(POWER_OFS)) begin
                power_ff <= pwdata_in[POWER_VALID_BIT:0];
            end
            if (wr_hit(IRQ_MASK_OFS)) begin
                irq_mask_ff <= pwdata_in[IRQ_W-1:0];
            end
        end
    end

    // control register notes:
    // only the documented fields are writable;
    // the mask keeps reserved bits at zero.
    // a cause flag set in the same cycle as a
    // clearing write stays set, so an event is
    // never lost to a racing software clear.
    // writing one to a cause flag sets it,
    // which lets software test the handler.
    // transceiver control; cause flags set wins over clear
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            xcvr_ctl_ff <= REG_RST;
        end else begin
            if (wr_hit(XCVR_CTL_OFS)) begin
                xcvr_ctl_ff <= pwdata_in & XCVR_CTL_WMASK;
            end
            if (res_se0) begin
                xcvr_ctl_ff[CAUSE_SE0_BIT] <= 1'b1;
            end
            if (res_k) begin
                xcvr_ctl_ff[CAUSE_K_BIT] <= 1'b1;
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            irq_stat_ff <= '0;
        end else if (wr_hit(IRQ_STAT_OFS)) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata_in[IRQ_W-1:0]) | events;
        end else begin
            irq_stat_ff <= irq_stat_ff | events;
        end
    end

    // filter notes:
    // the counter width bounds the field; with
    // the default width every field value fits.
    // a new raw value restarts the count, so a
    // glitch shorter than the delay is dropped.
    // total latency is the delay plus the one
    // cycle in which the candidate is taken.
    // the limit is recomputed every cycle.
    // filter length: two to the field, minus one
    assign ls_limit = DLY_CNT_W'((32'h1 << xcvr_ctl_ff[FILT_MSB:FILT_LSB]) - 32'h1);

    // linestate filter: change must stand for the full delay
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ls_filt_ff <= '0;
            ls_cand_ff <= '0;
            ls_cnt_ff <= '0;
        end else if (linestate_in != ls_cand_ff) begin
            ls_cand_ff <= linestate_in; // restart on any new value
            ls_cnt_ff <= '0;
        end else if (ls_cand_ff != ls_filt_ff) begin
            if (ls_cnt_ff >= ls_limit) begin
                ls_filt_ff <= ls_cand_ff;
                ls_cnt_ff <= '0;
            end else begin
                ls_cnt_ff <= ls_cnt_ff + 1'b1;
            end
        end else begin
            ls_cnt_ff <= '0;
        end
    end

    // resume notes:
    // the pulse repeats while the line holds
    // k or se0 in suspend; the link layer is
    // expected to leave suspend on the first.
    // with the enable clear nothing happens.
    // resume high one cycle after each cycle of auto-resume
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            resume_ff <= 1'b0;
        end else begin
            resume_ff <= res_k || res_se0;
        end
    end

    // output notes:
    // every output below is a flop or a plain
    // copy of one, except irq which is the and
    // of two flop vectors; no pin below sees a path
    // from an input within the same cycle.
    // outputs from register state
    assign rx_valid_out = rx_valid_ff;
    assign rx_endp_out = rx_endp_ff;
    assign linestate_filt_out = ls_filt_ff;
    assign resume_out = resume_ff;
    assign first_byte_port_pd_off_out = xcvr_ctl_ff[PD_OFF_BIT];
    assign second_byte_port_pd_off_out = xcvr_ctl_ff[PD_OFF_BIT];
    assign transceiver_config_pins_out = xcvr_ctl_ff[CFG_MSB:CFG_LSB];
    assign session_flag_mask_out = sess_mask_ff;
    assign power_sig_data_out = power_ff[7:0];
    assign power_sig_valid_out = power_ff[POWER_VALID_BIT];
    assign irq_out = |(irq_stat_ff & irq_mask_ff);
endmodule
`default_nettype wire

// ### core/uim_pkg.sv
// Purpose: constants for the usb interface manager token/phy registers
// Assumes: apb byte addresses, 32-bit data
// Notes: one aligned word per register
package uim_pkg;
    localparam int ADDR_W = 8; // apb address width
    localparam int DATA_W = 32; // apb data width
    // register byte offsets
    localparam logic [7:0] DEV_ADDR_OFS = 8'h08;
    localparam logic [7:0] FRAME_CNT_OFS = 8'h28;
    localparam logic [7:0] PID_OFS = 8'h2C;
    localparam logic [7:0] ENDP_OFS = 8'h30;
    localparam logic [7:0] SPECIAL_OFS = 8'h34;
    localparam logic [7:0] SESS_MASK_OFS = 8'h38;
    localparam logic [7:0] POWER_OFS = 8'h3C;
    localparam logic [7:0] XCVR_CTL_OFS = 8'h40;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h44;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h48;
    // field positions
    localparam int FRAME_W = 11; // frame counter width
    localparam int DEV_ADDR_W = 7; // device address width
    localparam int ENDP_VALID_BIT = 4; // endpoint valid flag
    localparam int POWER_VALID_BIT = 8; // power signalling valid
    localparam int PD_OFF_BIT = 18; // pulldown disable
    localparam int CAUSE_SE0_BIT = 13; // auto-resume was reset
    localparam int CAUSE_K_BIT = 12; // auto-resume was resume
    localparam int FILT_LSB = 8; // linestate delay field lsb
    localparam int FILT_MSB = 11; // linestate delay field msb
    localparam int SUSP_CTL_BIT = 7; // suspend controller resume
    localparam int CFG_LSB = 4; // config pins field lsb
    localparam int CFG_MSB = 6; // config pins field msb
    localparam logic [4:0] SPECIAL_TAG = 5'h10; // special endpoint or
    // writable bits of the control register
    localparam logic [31:0] XCVR_CTL_WMASK = 32'h0004_3FF0;
    // interrupt status bit positions
    localparam int IRQ_TOKEN = 0; // accepted token
    localparam int IRQ_SOF = 1; // start of frame seen
    localparam int IRQ_RES_K = 2; // auto-resume by k
    localparam int IRQ_RES_SE0 = 3; // auto-resume by se0
    localparam int IRQ_W = 4; // number of event bits
    // linestate codes
    localparam logic [1:0] LS_SE0 = 2'h0; // single ended zero
    localparam logic [1:0] LS_K = 2'h2; // k state
    // reset values
    localparam logic [31:0] REG_RST = 32'h0000_0000;
endpackage

// ### dv/uim_host_model.sv
// Purpose: usb side model, tokens, frames and line states
// Assumes: one token or frame strobe per cycle
// Notes: idle address and frame fields show inverted values
`timescale 1ns/1ns
`default_nettype none
module uim_host_model (
    input wire logic clk_sys_in,
    output logic tok_valid_in, sof_valid_in, suspended_in,
    output logic [3:0] tok_pid_in, tok_endp_in,
    output logic [6:0] tok_addr_in,
    output logic [10:0] sof_frame_in,
    output logic [1:0] linestate_in
);
    // quiet bus at time zero, line idles in j
    initial begin
        {tok_valid_in, sof_valid_in, suspended_in, tok_pid_in, tok_endp_in} = '0;
        {tok_addr_in, sof_frame_in} = '0;
        linestate_in = 2'h1;
    end
    // one token per call, back to back allowed
    task automatic tok(input logic [6:0] a, input logic [3:0] e, p);
        @(posedge clk_sys_in);
        tok_valid_in <= 1'b1;
        tok_addr_in <= a;
        tok_endp_in <= e;
        tok_pid_in <= p;
    endtask
    // release strobes, stale address and frame inverted
    task automatic idle();
        @(posedge clk_sys_in);
        tok_valid_in <= 1'b0;
        sof_valid_in <= 1'b0;
        tok_addr_in <= ~tok_addr_in;
        sof_frame_in <= ~sof_frame_in;
    endtask
    // single start of frame
    task automatic sof(input logic [10:0] f);
        @(posedge clk_sys_in);
        sof_valid_in <= 1'b1;
        sof_frame_in <= f;
        idle();
    endtask
    // se0 or k while suspended asks for auto-resume
    task automatic line(input logic [1:0] v, input logic s);
        @(posedge clk_sys_in);
        linestate_in <= v;
        suspended_in <= s;
    endtask
endmodule
`default_nettype wire

// ### dv/uim_token_phy_regs_sva.sv
// Purpose: port checker for the token and phy register block
// Assumes: zero wait apb, shadows of software fields
// Notes: bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module uim_chk
    import uim_pkg::*;
(
    input wire logic clk_sys_in, reset_in, psel_in, penable_in, pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    input wire logic [31:0] session_flag_mask_out,
    input wire logic pslverr_out, tok_valid_in, rx_valid_out, suspended_in, resume_out,
    input wire logic [6:0] tok_addr_in,
    input wire logic [3:0] tok_endp_in,
    input wire logic [4:0] rx_endp_out,
    input wire logic first_byte_port_pd_off_out, second_byte_port_pd_off_out,
    input wire logic [2:0] transceiver_config_pins_out,
    input wire logic [7:0] power_sig_data_out,
    input wire logic power_sig_valid_out
);
    logic wr; // completed write
    logic hit; // token endpoint marked special
    logic [6:0] dev_ff; // shadow device address
    logic [15:0] spec_ff; // shadow special mask
    logic [18:0] ctl_ff; // shadow software control bits
    assign wr = psel_in && penable_in && pwrite_in;
    assign hit = spec_ff[tok_endp_in];
    // shadows follow completed writes
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            dev_ff <= 7'h00;
            spec_ff <= 16'h0000;
            ctl_ff <= 19'h00000;
        end else if (wr && paddr_in == DEV_ADDR_OFS) begin
            dev_ff <= pwdata_in[6:0];
        end else if (wr && paddr_in == SPECIAL_OFS) begin
            spec_ff <= pwdata_in[15:0];
        end else if (wr && paddr_in == XCVR_CTL_OFS) begin
            ctl_ff <= pwdata_in[18:0] & 19'h40FF0;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    pd_off_a: assert property (
        first_byte_port_pd_off_out == ctl_ff[18] && second_byte_port_pd_off_out == ctl_ff[18])
        else $error("pulldown outputs differ from control");
    cfg_pins_a: assert property (transceiver_config_pins_out == ctl_ff[6:4])
        else $error("config pins differ from control");
    tok_take_a: assert property (tok_valid_in && tok_addr_in == dev_ff |=>
        rx_valid_out && rx_endp_out == {$past(hit), $past(tok_endp_in)})
        else $error("accepted token not delivered");
    tok_drop_a: assert property (!(tok_valid_in && tok_addr_in == dev_ff) |=>
        !rx_valid_out) else $error("unexpected receive strobe");
    mask_wr_a: assert property (wr && paddr_in == SESS_MASK_OFS |=>
        session_flag_mask_out == $past(pwdata_in)) else $error("flag mask not written");
    power_wr_a: assert property (wr && paddr_in == POWER_OFS |=>
        {power_sig_valid_out, power_sig_data_out} == $past(pwdata_in[8:0]))
        else $error("power word not written");
    err_map_a: assert property (
        psel_in && penable_in && paddr_in == 8'h4C |-> pslverr_out)
        else $error("unmapped access not refused");
    resume_gate_a: assert property (
        resume_out |-> $past(ctl_ff[7]) && $past(suspended_in))
        else $error("resume without enable and suspend");
endmodule
bind uim_token_phy_regs uim_chk u_chk (.clk_sys_in, .reset_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .session_flag_mask_out, .pslverr_out, .tok_valid_in,
    .rx_valid_out, .suspended_in, .resume_out, .tok_addr_in, .tok_endp_in, .rx_endp_out,
    .first_byte_port_pd_off_out, .second_byte_port_pd_off_out, .transceiver_config_pins_out,
    .power_sig_data_out, .power_sig_valid_out);
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: self-checking bench for the token and phy register block
// Assumes: apb master task, host model on the usb side
// Notes: expectations come from the bench model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import uim_pkg::*;
    logic clk_sys_in = 1'b0, reset_in = 1'b1; // clock and reset
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0; // apb control
    logic [7:0] paddr_in = 8'h00; // apb address
    logic [31:0] pwdata_in = 32'h0, prdata_out, session_flag_mask_out, rd; // data
    logic pready_out, pslverr_out, rx_valid_out, resume_out, irq_out, er; // status
    logic tok_valid_in, sof_valid_in, suspended_in, power_sig_valid_out; // strobes
    logic first_byte_port_pd_off_out, second_byte_port_pd_off_out; // pulldowns
    logic [3:0] tok_pid_in, tok_endp_in;
    logic [6:0] tok_addr_in;
    logic [10:0] sof_frame_in;
    logic [1:0] linestate_in, linestate_filt_out;
    logic [4:0] rx_endp_out;
    logic [2:0] transceiver_config_pins_out;
    logic [7:0] power_sig_data_out;
    int miscompares = 0, checks = 0; // verdict counters
    logic [4:0] exp_q[$]; // expected delivered endpoints
    logic [7:0] ofs[9] = '{DEV_ADDR_OFS, FRAME_CNT_OFS, PID_OFS, ENDP_OFS, SPECIAL_OFS,
        SESS_MASK_OFS, POWER_OFS, XCVR_CTL_OFS, IRQ_MASK_OFS};
    logic [31:0] msk[9] = '{32'h7F, 32'h7FF, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF_FFFF, 32'h1FF,
        XCVR_CTL_WMASK, 32'hF};
    uim_token_phy_regs #(.DLY_CNT_W(16)) uut (.clk_sys_in, .reset_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .tok_valid_in, .tok_pid_in, .tok_addr_in, .tok_endp_in, .sof_valid_in, .sof_frame_in,
        .rx_valid_out, .rx_endp_out, .linestate_in, .linestate_filt_out, .suspended_in,
        .resume_out, .first_byte_port_pd_off_out, .second_byte_port_pd_off_out,
        .transceiver_config_pins_out, .session_flag_mask_out, .power_sig_data_out,
        .power_sig_valid_out, .irq_out);
    uim_host_model host (.clk_sys_in, .tok_valid_in, .sof_valid_in, .suspended_in,
        .tok_pid_in, .tok_endp_in, .tok_addr_in, .sof_frame_in, .linestate_in);
    // 4 ns period
    always #2 clk_sys_in = ~clk_sys_in;
    // compare and count
    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int i = 0; i < 20 && pready_out !== 1'b1; i++) @(posedge clk_sys_in);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // receive port against the queue
    always @(negedge clk_sys_in) begin
        if (!reset_in && rx_valid_out === 1'b1) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk(32'(rx_endp_out), 32'(exp_q.pop_front()));
        end
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        stop_test();
    end
    initial begin
        logic [31:0] d;
        logic [6:0] a;
        logic [3:0] p, le, lp;
        logic [15:0] sp;
        int n;
        void'($urandom(32'hf32d));
        repeat (20) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, REG_RST);
            d = $urandom;
            apb(1'b1, ofs[i], d);
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, d & msk[i]);
            chk(32'(er), 32'h0);
        end
        apb(1'b1, 8'h4C, $urandom);
        apb(1'b0, 8'h4C, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        sp = 16'($urandom);
        apb(1'b1, SPECIAL_OFS, 32'(sp));
        apb(1'b1, DEV_ADDR_OFS, 32'h2A);
        apb(1'b1, IRQ_MASK_OFS, 32'h0);
        apb(1'b1, IRQ_STAT_OFS, 32'hF);
        // back to back tokens, every endpoint, mixed addresses
        for (int i = 0; i < 16; i++) begin
            a = (i == 15 || $urandom % 2) ? 7'h2A : 7'($urandom);
            p = 4'($urandom);
            if (a == 7'h2A) begin
                exp_q.push_back({sp[i], 4'(i)});
                le = 4'(i);
                lp = p;
            end
            host.tok(a, 4'(i), p);
        end
        host.idle();
        repeat (3) @(posedge clk_sys_in);
        chk(32'(exp_q.size()), 32'h0);
        apb(1'b0, PID_OFS, 32'h0);
        chk(rd, 32'(lp));
        apb(1'b0, ENDP_OFS, 32'h0);
        chk(rd, 32'({1'b1, le}));
        d = $urandom % 2048;
        host.sof(11'(d));
        apb(1'b0, FRAME_CNT_OFS, 32'h0);
        chk(rd, d);
        // filter depth 8: short glitch dropped, long change timed
        apb(1'b1, XCVR_CTL_OFS, 32'h300);
        host.line(LS_K, 1'b0);
        repeat (4) @(posedge clk_sys_in);
        host.line(2'h1, 1'b0);
        repeat (12) @(negedge clk_sys_in);
        chk(32'(linestate_filt_out), 32'h1);
        host.line(LS_K, 1'b0);
        n = 0;
        while (linestate_filt_out !== LS_K && n < 40) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(32'(n >= 8 && n <= 11), 32'h1);
        // auto-resume by k, by se0, and disabled
        for (int i = 0; i < 3; i++) begin
            d = (i == 2) ? 32'h0 : 32'h80;
            apb(1'b1, XCVR_CTL_OFS, d);
            host.line(i == 1 ? LS_SE0 : LS_K, 1'b1);
            repeat (8) @(posedge clk_sys_in);
            host.line(2'h1, 1'b0);
            repeat (8) @(posedge clk_sys_in);
            apb(1'b0, XCVR_CTL_OFS, 32'h0);
            chk(rd, d | (i == 2 ? 32'h0 : 32'h1 << (i ? CAUSE_SE0_BIT : CAUSE_K_BIT)));
        end
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'hF);
        chk(32'(irq_out), 32'h0);
        apb(1'b1, IRQ_MASK_OFS, 32'h2);
        repeat (2) @(negedge clk_sys_in);
        chk(32'(irq_out), 32'h1);
        apb(1'b1, IRQ_STAT_OFS, 32'h2);
        repeat (2) @(negedge clk_sys_in);
        chk(32'(irq_out), 32'h0);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'hD);
        stop_test();
    end
endmodule
`default_nettype wire
